/* design/uart_err_pkg.sv */
/*
 * Constants shared by the receive data and error status block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 50 MHz clock and classic Wishbone with 32-bit data.
 */
package uart_err_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BAUD_DEFAULT = 115200;
    localparam int unsigned OVERSAMPLE = 16;
    localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT));
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [2:0] DATA_LAST = 3'h7;

    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    localparam int unsigned DR_OE_BIT = 11;
    localparam int unsigned DR_BREAK_BIT = 10;
    localparam int unsigned DR_PARITY_BIT = 9;
    localparam int unsigned DR_FRAMING_BIT = 8;

    localparam int unsigned ST_OE_BIT = 3;
    localparam int unsigned ST_BREAK_BIT = 2;
    localparam int unsigned ST_PARITY_BIT = 1;
    localparam int unsigned ST_FRAMING_BIT = 0;

    localparam int unsigned IRQ_LSB = 7;

    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned CTRL_PAR_EN_BIT = 1;
    localparam int unsigned CTRL_EVEN_PARITY_SELECT_BIT = 2;
    localparam int unsigned CTRL_STICK_PARITY_SELECT_BIT = 3;
    localparam int unsigned CTRL_DIV_LSB = 16;
    localparam logic CTRL_FIFO_EN_RESET = 1'b1;
endpackage

/* design/uart_rx_data_error_status.sv */
/*
 * Character data port and receive error status of a serial port, with receive
 * FIFO, transmit holding register and serialiser, Wishbone classic slave and
 * error interrupt. Assumes a 50 MHz clock and an asynchronous receive pin.
 */
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Data read returns oldest received char in 7:0; write queues char to send.
// - Data bit 11 shows overrun, cleared once a new character is stored.
// - Overrun discards incoming char, keeps FIFO; status bit 3 reports overrun.
// - Break flagged in data bit 10 and status bit 2 after a low word.
// - A break loads exactly one zero character into the FIFO.
// - After break, wait for line high and a fresh start bit.
// - Parity error in data bit 9, status bit 1, per even and stick selects.
// - Framing error in data bit 8, status bit 0 when stop bit is low.
// - Break, parity and framing flags are stored with each FIFO character.
// - Status register shows overrun, break, parity, framing in bits 3 to 0.
// - Any write to the status register clears all four flags except an overrun arriving in that same cycle.
// - FIFO disabled means storage of a single entry.
// - Error interrupt fires on the four errors, bits 7 to 10.
module uart_rx_data_error_status
    import uart_err_pkg::*;
#(
    parameter int FIFO_DEPTH = 32,
    parameter int FIFO_AW = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_i,
    output logic tx_o,
    output logic irq_o
);
    // ********************************************************************
    // Synchronisers, clocking and bus decode
    // ********************************************************************
    logic rx_s1_ff, rx_s2_ff, rx_s3_ff, rx_lvl_ff;
    logic [15:0] baud_div_ff, baud_cnt_ff;
    logic tick_ff;
    logic fifo_en_ff, par_en_ff, even_parity_select_ff, stick_parity_select_ff;
    logic req, wr, rd;
    logic char_valid, ch_framing, ch_parity, ch_break;
    logic [7:0] ch_data;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
            rx_s3_ff <= 1'b1;
            rx_lvl_ff <= 1'b1;
        end else begin
            rx_s1_ff <= rx_i;
            rx_s2_ff <= rx_s1_ff;
            rx_s3_ff <= rx_s2_ff;
            if (rx_s2_ff == rx_s3_ff) begin
                rx_lvl_ff <= rx_s3_ff;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (baud_cnt_ff + 16'h0001 >= baud_div_ff) begin
                baud_cnt_ff <= 16'h0000;
                tick_ff <= 1'b1;
            end else begin
                baud_cnt_ff <= baud_cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_en_ff <= CTRL_FIFO_EN_RESET;
            par_en_ff <= 1'b0;
            even_parity_select_ff <= 1'b0;
            stick_parity_select_ff <= 1'b0;
            baud_div_ff <= BAUD_DIV_RESET;
        end else if (wr && wb_adr_i == ADDR_CTRL) begin
            if (wb_sel_i[0]) begin
                fifo_en_ff <= wb_dat_i[CTRL_FIFO_EN_BIT];
                par_en_ff <= wb_dat_i[CTRL_PAR_EN_BIT];
                even_parity_select_ff <= wb_dat_i[CTRL_EVEN_PARITY_SELECT_BIT];
                stick_parity_select_ff <= wb_dat_i[CTRL_STICK_PARITY_SELECT_BIT];
            end
            if (wb_sel_i[3:2] == 2'b11) begin
                baud_div_ff <= wb_dat_i[CTRL_DIV_LSB +: 16];
            end
        end
    end

    uart_rx_frame uart_rx_frame_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_ff),
        .rx_i(rx_lvl_ff),
        .par_en_i(par_en_ff),
        .even_parity_select_i(even_parity_select_ff),
        .stick_parity_select_i(stick_parity_select_ff),
        .char_valid_o(char_valid),
        .char_data_o(ch_data),
        .framing_error_o(ch_framing),
        .parity_error_o(ch_parity),
        .break_error_o(ch_break)
    );

    // ********************************************************************
    // Receive FIFO and error flags
    // ********************************************************************
    logic [10:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [FIFO_AW:0] count_ff;
    logic [FIFO_AW:0] cap;
    logic full, push, pop, overrun, ovr_live_ff;
    logic [10:0] top;
    logic [3:0] status_ff;

    assign cap = fifo_en_ff ? (FIFO_AW+1)'(FIFO_DEPTH) : (FIFO_AW+1)'(1);
    assign full = count_ff >= cap;
    assign push = char_valid & ~full;
    assign overrun = char_valid & full;
    assign pop = rd & (wb_adr_i == ADDR_DATA) & (count_ff != '0);
    assign top = mem[rd_ptr_ff];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= {ch_break, ch_parity, ch_framing, ch_data};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == FIFO_AW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovr_live_ff <= 1'b0;
        end else if (overrun) begin
            ovr_live_ff <= 1'b1;
        end else if (push) begin
            ovr_live_ff <= 1'b0;
        end
    end

    logic [3:0] st_set;
    assign st_set = {overrun, pop ? top[10:8] : 3'b000};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= 4'h0;
        end else if (wr && wb_adr_i == ADDR_STATUS) begin
            status_ff <= st_set;
        end else begin
            status_ff <= status_ff | st_set;
        end
    end

    // ********************************************************************
    // Error interrupt
    // ********************************************************************
    logic [3:0] irq_stat_ff, irq_mask_ff, irq_set;

    assign irq_set = {overrun, char_valid & ch_break, char_valid & ch_parity, char_valid & ch_framing};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= 4'h0;
            irq_mask_ff <= 4'h0;
            irq_o <= 1'b0;
        end else begin
            if (rd && wb_adr_i == ADDR_IRQ_STAT) begin
                irq_stat_ff <= irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            if (wr && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[1:0] == 2'b11) begin
                irq_mask_ff <= wb_dat_i[IRQ_LSB +: 4];
            end
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ********************************************************************
    // Transmit holding register and serialiser
    // ********************************************************************
    logic [7:0] tx_hold_ff;
    logic tx_full_ff, tx_busy_ff;
    logic [10:0] tx_shift_ff;
    logic [3:0] tx_bits_ff, tx_sub_ff;
    logic tx_par;

    assign tx_par = stick_parity_select_ff ? ~even_parity_select_ff
        : (even_parity_select_ff ? ^tx_hold_ff : ~^tx_hold_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_hold_ff <= 8'h00;
            tx_full_ff <= 1'b0;
            tx_busy_ff <= 1'b0;
            tx_shift_ff <= 11'h7ff;
            tx_bits_ff <= 4'h0;
            tx_sub_ff <= 4'h0;
            tx_o <= 1'b1;
        end else begin
            if (wr && wb_adr_i == ADDR_DATA && wb_sel_i[0] && !tx_full_ff) begin
                tx_hold_ff <= wb_dat_i[7:0];
                tx_full_ff <= 1'b1;
            end else if (!tx_busy_ff && tx_full_ff) begin
                tx_full_ff <= 1'b0;
                tx_busy_ff <= 1'b1;
                tx_sub_ff <= 4'h0;
                tx_shift_ff <= {1'b1, tx_par, tx_hold_ff, 1'b0};
                tx_bits_ff <= par_en_ff ? 4'hb : 4'ha;
            end
            if (tx_busy_ff && tick_ff) begin
                tx_sub_ff <= tx_sub_ff + 4'h1;
                if (tx_sub_ff == SUB_LAST) begin
                    tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                    tx_bits_ff <= tx_bits_ff - 4'h1;
                    if (tx_bits_ff == 4'h1) begin
                        tx_busy_ff <= 1'b0;
                    end
                end
            end
            tx_o <= tx_busy_ff ? ((tx_bits_ff == 4'h1 && !par_en_ff) ? 1'b1 : tx_shift_ff[0]) : 1'b1;
        end
    end

    // ********************************************************************
    // Bus answer
    // ********************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                case (wb_adr_i)
                    ADDR_DATA: wb_dat_o <= {20'h00000, ovr_live_ff, top};
                    ADDR_STATUS: wb_dat_o <= {28'h0000000, status_ff};
                    ADDR_CTRL: wb_dat_o <= {baud_div_ff, 12'h000, stick_parity_select_ff,
                        even_parity_select_ff, par_en_ff, fifo_en_ff};
                    ADDR_IRQ_STAT: wb_dat_o <= {21'h000000, irq_stat_ff, 7'h00};
                    ADDR_IRQ_MASK: wb_dat_o <= {21'h000000, irq_mask_ff, 7'h00};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single cycle after request.");

    AST_OVR_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        overrun && !pop |=> count_ff == $past(count_ff) && wr_ptr_ff == $past(wr_ptr_ff))
        else $error("Overrun character was written to full FIFO.");

    AST_OVR_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
        overrun |=> ovr_live_ff && status_ff[ST_OE_BIT])
        else $error("Overrun did not set both flags.");

    AST_OVR_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        push |=> !ovr_live_ff)
        else $error("Overrun flag stayed after a store.");

    AST_ECR_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == ADDR_STATUS && st_set == 4'h0 |=> status_ff == 4'h0)
        else $error("Status write did not clear flags.");

    AST_POP_READ: assert property (@(posedge clk_i) disable iff (rst_i)
        pop && !push |=> count_ff == $past(count_ff) - 1'b1 && wb_dat_o[10:0] == $past(top)
            && (status_ff[2:0] & $past(top[10:8])) == $past(top[10:8]))
        else $error("Data read did not pop the top entry.");

    AST_SINGLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !fifo_en_ff && count_ff <= 1 |=> count_ff <= 1)
        else $error("Single entry mode held more than one.");

    AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_stat_ff & irq_mask_ff) != 4'h0 |=> irq_o)
        else $error("Unmasked error did not raise interrupt.");

    COV_OVERRUN: cover property (@(posedge clk_i) disable iff (rst_i) overrun);
    COV_CLEAR: cover property (@(posedge clk_i) disable iff (rst_i) wr && wb_adr_i == ADDR_STATUS && status_ff != 4'h0);
    COV_FULL_POP: cover property (@(posedge clk_i) disable iff (rst_i) full && pop);
endmodule // uart_rx_data_error_status
`default_nettype wire

/* design/uart_rx_frame.sv */
/*
 * Serial frame receiver: eight data bits, optional parity, one stop bit, break
 * detection. Assumes rx_i is already synchronised and tick_i pulses at 16x baud.
 */
`timescale 1ns/100ps
`default_nettype none
module uart_rx_frame
    import uart_err_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic rx_i,
    input wire logic par_en_i,
    input wire logic even_parity_select_i,
    input wire logic stick_parity_select_i,
    output logic char_valid_o,
    output logic [7:0] char_data_o,
    output logic framing_error_o,
    output logic parity_error_o,
    output logic break_error_o
);
    typedef enum logic [2:0] {IDLE, START, DATA, PAR, STOP, BRK_WAIT} rx_state_type;

    rx_state_type state_ff;
    logic [3:0] sub_ff;
    logic [2:0] bit_ff;
    logic [7:0] shift_ff;
    logic par_bit_ff;
    logic all_zero_ff;
    logic exp_par;

    assign exp_par = stick_parity_select_i ? ~even_parity_select_i : (even_parity_select_i ? ^shift_ff : ~^shift_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= IDLE;
            sub_ff <= 4'h0;
            bit_ff <= 3'h0;
            shift_ff <= 8'h00;
            par_bit_ff <= 1'b0;
            all_zero_ff <= 1'b0;
            char_valid_o <= 1'b0;
            char_data_o <= 8'h00;
            framing_error_o <= 1'b0;
            parity_error_o <= 1'b0;
            break_error_o <= 1'b0;
        end else begin
            char_valid_o <= 1'b0;
            case (state_ff)
                IDLE: begin
                    sub_ff <= 4'h0;
                    if (!rx_i) begin
                        state_ff <= START;
                    end
                end
                START: begin
                    if (tick_i) begin
                        if (sub_ff == SUB_MID) begin
                            sub_ff <= 4'h0;
                            bit_ff <= 3'h0;
                            all_zero_ff <= 1'b1;
                            state_ff <= rx_i ? IDLE : DATA;
                        end else begin
                            sub_ff <= sub_ff + 4'h1;
                        end
                    end
                end
                DATA: begin
                    if (tick_i) begin
                        sub_ff <= sub_ff + 4'h1;
                        if (sub_ff == SUB_LAST) begin
                            shift_ff <= {rx_i, shift_ff[7:1]};
                            all_zero_ff <= all_zero_ff & ~rx_i;
                            bit_ff <= bit_ff + 3'h1;
                            if (bit_ff == DATA_LAST) begin
                                state_ff <= par_en_i ? PAR : STOP;
                            end
                        end
                    end
                end
                PAR: begin
                    if (tick_i) begin
                        sub_ff <= sub_ff + 4'h1;
                        if (sub_ff == SUB_LAST) begin
                            par_bit_ff <= rx_i;
                            all_zero_ff <= all_zero_ff & ~rx_i;
                            state_ff <= STOP;
                        end
                    end
                end
                STOP: begin
                    if (tick_i) begin
                        sub_ff <= sub_ff + 4'h1;
                        if (sub_ff == SUB_LAST) begin
                            char_valid_o <= 1'b1;
                            if (all_zero_ff && !rx_i) begin
                                char_data_o <= 8'h00;
                                break_error_o <= 1'b1;
                                framing_error_o <= 1'b0;
                                parity_error_o <= 1'b0;
                                state_ff <= BRK_WAIT;
                            end else begin
                                char_data_o <= shift_ff;
                                break_error_o <= 1'b0;
                                framing_error_o <= ~rx_i;
                                parity_error_o <= par_en_i & (par_bit_ff != exp_par);
                                state_ff <= IDLE;
                            end
                        end
                    end
                end
                BRK_WAIT: begin
                    if (rx_i) begin
                        state_ff <= IDLE;
                    end
                end
                default: begin
                    state_ff <= IDLE;
                end
            endcase
        end
    end

    AST_BREAK_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        char_valid_o && break_error_o |-> char_data_o == 8'h00 && !framing_error_o && !parity_error_o)
        else $error("Break did not load a zero character.");

    AST_BREAK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (char_valid_o && break_error_o) ##0 (!rx_i) [*2] |-> !char_valid_o && state_ff == BRK_WAIT)
        else $error("Receiver left break wait while line low.");

    AST_PARITY_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        char_valid_o && !$past(par_en_i) |-> !parity_error_o)
        else $error("Parity error flagged with parity off.");

    COV_BREAK: cover property (@(posedge clk_i) disable iff (rst_i) char_valid_o && break_error_o);
endmodule // uart_rx_frame
`default_nettype wire

/* tb/uart_rx_data_error_status_test.sv */
/*
 * Self-checking bench of the receive data and error status block with a queue model.
 * Assumes the design package and a serial source model driving the receive pin.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module uart_rx_data_error_status_test;
    import uart_err_pkg::*;
    localparam int DIV = 2;
    localparam int BIT_CLKS = 16 * DIV;
    localparam int CAP = 4;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_i, tx_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic [10:0] q[$];
    logic ovr;
    logic [3:0] st, ctrl;
    logic [7:0] d;
    int failures = 0, checks = 0, cycles = 0, seed = 21179, cap = CAP, n;
    // ****************************************
    // Instances and clock
    // ****************************************
    uart_rx_data_error_status #(.FIFO_DEPTH(CAP), .FIFO_AW(2)) uart_rx_data_error_status_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o));
    uart_serial_source #(.BIT_CLKS(BIT_CLKS)) uart_serial_source_i (.clk_i(clk_i), .rx_o(rx_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ****************************************
    // Tasks and model
    // ****************************************
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= dw;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        if (k >= 100) begin
            failures++;
            tally_and_finish();
        end
        dr = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic pexp(input logic [7:0] v);
        return ctrl[3] ? ~ctrl[2] : (ctrl[2] ? ^v : ~^v);
    endfunction
    task automatic setc(input logic [3:0] c);
        ctrl = c;
        wb(1'b1, ADDR_CTRL, {16'(DIV), 12'h0, c}, r);
    endtask
    task automatic mstore(input logic [10:0] e);
        if (q.size() < cap) begin
            q.push_back(e);
            ovr = 1'b0;
        end else begin
            ovr = 1'b1;
            st[3] = 1'b1;
        end
    endtask
    task automatic rxc(input logic badp, input logic stop);
        logic [7:0] v;
        v = 8'($random(seed)) | {7'h0, ~stop};
        uart_serial_source_i.frame(v, ctrl[1], pexp(v) ^ badp, stop);
        mstore({1'b0, ctrl[1] & badp, ~stop, v});
    endtask
    task automatic rdd();
        logic [10:0] e;
        e = q.pop_front();
        wb(1'b0, ADDR_DATA, 32'h0, r);
        `CHK(r, {20'h0, ovr, e})
        st[2:0] = st[2:0] | e[10:8];
    endtask
    task automatic rds();
        wb(1'b0, ADDR_STATUS, 32'h0, r);
        `CHK(r, {28'h0, st})
    endtask
    task automatic clr();
        wb(1'b1, ADDR_STATUS, $random(seed), r);
        st = 4'h0;
        rds();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        ovr = 1'b0;
        st = 4'h0;
        ctrl = 4'h1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rds();
        wb(1'b0, 8'h20, 32'h0, r);
        `CHK(r, 32'h0)
        for (int m = 0; m < 4; m++) begin
            setc({2'(m), 2'b11});
            rxc(1'b0, 1'b1);
            rxc(1'b1, 1'b1);
            rdd();
            rdd();
            rds();
            clr();
        end
        setc(4'h1);
        rxc(1'b0, 1'b0);
        rdd();
        rds();
        clr();
        uart_serial_source_i.brk(14);
        mstore(11'h400);
        rdd();
        rds();
        clr();
        rxc(1'b0, 1'b1);
        rdd();
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, r);
        rxc(1'b0, 1'b0);
        `CHK(irq_o, 1'b0)
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, r);
        `CHK(r, 32'h80)
        rdd();
        clr();
        wb(1'b1, ADDR_IRQ_MASK, 32'h780, r);
        setc(4'h3);
        rxc(1'b1, 1'b1);
        `CHK(irq_o, 1'b1)
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, r);
        `CHK(r, 32'h100)
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        rdd();
        clr();
        for (int f = 1; f >= 0; f--) begin
            cap = (f == 1) ? CAP : 1;
            setc({3'b000, f[0]});
            repeat (cap + 1) rxc(1'b0, 1'b1);
            rds();
            repeat (cap) rdd();
            rxc(1'b0, 1'b1);
            rdd();
            clr();
        end
        d = 8'($random(seed));
        wb(1'b1, ADDR_DATA, {24'h0, d}, r);
        for (n = 0; tx_o !== 1'b0 && n < 2000; n++) @(posedge clk_i);
        if (n >= 2000) begin
            failures++;
        end
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            r[i] = tx_o;
        end
        `CHK(r[7:0], d)
        tally_and_finish();
    end
endmodule // uart_rx_data_error_status_test
`default_nettype wire

/* tb/uart_serial_source.sv */
/*
 * Model of the remote serial transmitter that drives the receive line.
 * Assumes its tasks are called right after a rising clock edge from one process.
 */
`timescale 1ns/100ps
`default_nettype none
module uart_serial_source #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk_i,
    output logic rx_o
);
    // ****************************************
    // Line driver
    // ****************************************
    initial begin
        rx_o = 1'b1;
    end
    task automatic hold(input logic b, input int n);
        rx_o <= b;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic frame(input logic [7:0] d, input logic par_on, input logic pbit, input logic stop);
        hold(1'b0, BIT_CLKS);
        for (int i = 0; i < 8; i++) begin
            hold(d[i], BIT_CLKS);
        end
        if (par_on) begin
            hold(pbit, BIT_CLKS);
        end
        // A low stop bit ends early so the line is high again before a false start is rechecked.
        hold(stop, BIT_CLKS * 3 / 4);
        hold(1'b1, 2 * BIT_CLKS + BIT_CLKS / 4);
    endtask
    task automatic brk(input int bits);
        hold(1'b0, bits * BIT_CLKS);
        hold(1'b1, 2 * BIT_CLKS);
    endtask
endmodule // uart_serial_source
`default_nettype wire
